// ==== dpwm_top.sv ====
`timescale 1ns/100ps
// Operation
// - Fine load copies 15 bits of RAM nibbles 0..3, less nibble 3 top bit.
// - Fine waveform from low 14 bits; top bit can drive pin directly.
// - Fine period about 122 Hz made of 500 ns slices, width step one slice.
// - Fine period is 64 sub-periods of 256 slices each.
// - Upper 8 bits give high slices in every sub-period.
// - Lower 6 bits each add one slice in spread sub-periods.
// - RAM writes alone do nothing; output inactive until first load.
// - Fixed option inverts each channel's polarity.
// - Coarse load takes low 3 bits of B and 4 bits of A.
// - Coarse slice 16 us, period 64 slices, about 1 kHz.
// - Coarse zero is always low; bits 0..5 add spread high slices.
// - Coarse top bit set gives high for all 64 slices.
// - Coarse channel gives 65 duty levels.
// - Coarse pin can serve as a plain one-bit output.
// - After reset coarse pin inactive until its latch is loaded, except in port mode.
// - Low reset pin resets; reset lasts 3 machine cycles after release.
// - Reset stretch derives from the 4 MHz oscillator rate; slice timing from the 50 MHz system clock.
module dpwm_top #(
  parameter bit FINE_INVERT = 1'b0,
  parameter bit COARSE_INVERT = 1'b0,
  parameter int unsigned FINE_SLICE_CYC = dpwm_pkg::FINE_SLICE_CYC,
  parameter int unsigned COARSE_SLICE_CYC = dpwm_pkg::COARSE_SLICE_CYC,
  parameter int unsigned RST_STRETCH_CYC = dpwm_pkg::RST_STRETCH_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_n_pin,
  input wire logic fine_load,
  input wire dpwm_pkg::dpwm_fine_src_t fine_src,
  input wire logic fine_port_mode,
  input wire logic coarse_latch_load_instr,
  input wire dpwm_pkg::dpwm_coarse_src_t coarse_src,
  input wire logic coarse_port_mode,
  input wire logic coarse_port_data,
  output logic fine_pwm_o,
  output logic coarse_pwm_port_o,
  output logic coarse_pwm_port_oe,
  output logic rst_int_o
);

  localparam logic [9:0] RST_LOAD =
    dpwm_pkg::RST_CNT_W'(RST_STRETCH_CYC);

  logic [9:0] rst_cnt_r;
  logic rst_int_r;
  logic [14:0] fine_latch_r;
  logic [14:0] fine_act_r;
  logic fine_pend_r;
  logic fine_valid_r;
  logic [6:0] coarse_latch_r;
  logic [6:0] coarse_act_r;
  logic coarse_pend_r;
  logic coarse_valid_r;
  logic [13:0] fine_idx;
  logic fine_wrap;
  logic [5:0] coarse_idx;
  logic coarse_wrap;
  logic [8:0] fine_width;
  logic fine_high;
  logic coarse_high;
  logic fine_nxt;
  logic coarse_drive_high;

  ////////////////////////////////////////////////////////////////////
  // Internal reset, stretched after the pin returns high
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !reset_n_pin)
    begin
      rst_cnt_r <= RST_LOAD;
      rst_int_r <= 1'b1;
    end
    else if (rst_cnt_r != 10'h000)
    begin
      rst_cnt_r <= rst_cnt_r - 10'h001;
      rst_int_r <= 1'b1;
    end
    else
    begin
      rst_int_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rst_int_o <= 1'b1;
    else
      rst_int_o <= rst_int_r;
  end

  ////////////////////////////////////////////////////////////////////
  // Slice timebases, counts derived from the system clock rate
  dpwm_slice_gen #(
    .SLICE_CYC(FINE_SLICE_CYC),
    .IDX_W(dpwm_pkg::FINE_IDX_W)
  ) u_fine_gen (
    .sys_clk(sys_clk),
    .rst(rst_int_r),
    .idx(fine_idx),
    .tick(),
    .wrap(fine_wrap)
  );

  dpwm_slice_gen #(
    .SLICE_CYC(COARSE_SLICE_CYC),
    .IDX_W(dpwm_pkg::COARSE_IDX_W)
  ) u_coarse_gen (
    .sys_clk(sys_clk),
    .rst(rst_int_r),
    .idx(coarse_idx),
    .tick(),
    .wrap(coarse_wrap)
  );

  ////////////////////////////////////////////////////////////////////
  // Fine latch: loaded only by the load instruction, never by RAM writes
  always_ff @(posedge sys_clk)
  begin
    if (rst_int_r)
      fine_latch_r <= dpwm_pkg::FINE_LATCH_RST;
    else if (fine_load)
      fine_latch_r <= {fine_src.nib3[2:0], fine_src.nib2,
                       fine_src.nib1, fine_src.nib0};
  end

  // Pending flag: a load in the boundary cycle survives (set wins)
  always_ff @(posedge sys_clk)
  begin
    if (rst_int_r)
      fine_pend_r <= 1'b0;
    else
      fine_pend_r <= fine_load || (fine_pend_r && !fine_wrap);
  end

  // Active copy changes only at a full period boundary
  always_ff @(posedge sys_clk)
  begin
    if (rst_int_r)
    begin
      fine_act_r <= dpwm_pkg::FINE_LATCH_RST;
      fine_valid_r <= 1'b0;
    end
    else if (fine_wrap && fine_pend_r)
    begin
      fine_act_r <= fine_latch_r;
      fine_valid_r <= 1'b1;
    end
  end

  // Width: upper part plus one slice in spread sub-periods
  assign fine_width = {1'b0, fine_act_r[13:6]} +
    {8'h00, dpwm_pkg::dpwm_spread(fine_act_r[5:0],
                                  fine_idx[13:8] + 6'h01)};
  assign fine_high = ({1'b0, fine_idx[7:0]} < fine_width);

  // Port mode drives the spare top bit straight out
  always_comb
  begin
    fine_nxt = 1'b0;
    if (fine_port_mode)
      fine_nxt = fine_latch_r[dpwm_pkg::FINE_PORT_BIT];
    else if (fine_valid_r)
      fine_nxt = fine_high;
  end

  // Inversion is a build-time option, not a run-time control
  always_ff @(posedge sys_clk)
  begin
    if (rst_int_r)
      fine_pwm_o <= FINE_INVERT;
    else
      fine_pwm_o <= fine_nxt ^ FINE_INVERT;
  end

  ////////////////////////////////////////////////////////////////////
  // Coarse latch from B low bits over A
  always_ff @(posedge sys_clk)
  begin
    if (rst_int_r)
      coarse_latch_r <= dpwm_pkg::COARSE_LATCH_RST;
    else if (coarse_latch_load_instr)
      coarse_latch_r <= {coarse_src.reg_b, coarse_src.reg_a};
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_int_r)
      coarse_pend_r <= 1'b0;
    else
      coarse_pend_r <= coarse_latch_load_instr ||
                       (coarse_pend_r && !coarse_wrap);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_int_r)
    begin
      coarse_act_r <= dpwm_pkg::COARSE_LATCH_RST;
      coarse_valid_r <= 1'b0;
    end
    else if (coarse_wrap && coarse_pend_r)
    begin
      coarse_act_r <= coarse_latch_r;
      coarse_valid_r <= 1'b1;
    end
  end

  // Zero gives none, full bit gives all: 65 levels
  assign coarse_high = coarse_act_r[dpwm_pkg::COARSE_FULL_BIT] ||
    dpwm_pkg::dpwm_spread(coarse_act_r[5:0],
                          coarse_idx + 6'h01);

  always_comb
  begin
    coarse_drive_high = 1'b0;
    if (coarse_port_mode)
      coarse_drive_high = coarse_port_data;
    else
      coarse_drive_high = coarse_high;
  end

  // Open-drain pin: only a low level is driven, high is released.
  // Before the first load the pin stays released whatever the option, unless port mode drives it.
  always_ff @(posedge sys_clk)
  begin
    coarse_pwm_port_o <= 1'b0;
    if (rst_int_r)
      coarse_pwm_port_oe <= 1'b0;
    else if (!coarse_valid_r && !coarse_port_mode)
      coarse_pwm_port_oe <= 1'b0;
    else
      coarse_pwm_port_oe <= !(coarse_drive_high ^ COARSE_INVERT);
  end

endmodule // dpwm_top

// ==== dpwm_pkg.sv ====
package dpwm_pkg;

  // Clock and oscillator rates
  localparam int unsigned SYS_CLK_MHZ = 50;
  localparam int unsigned OSC_MHZ = 4;
  localparam int unsigned OSC_PER_MC = 16;

  // Fine channel timing
  localparam int unsigned FINE_SLICE_NS = 500;
  localparam int unsigned FINE_SLICE_CYC =
    (FINE_SLICE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned FINE_SLICES_PER_SUB = 256;
  localparam int unsigned FINE_SUBS = 64;
  localparam int unsigned FINE_IDX_W = 14;

  // Coarse channel timing
  localparam int unsigned COARSE_SLICE_US = 16;
  localparam int unsigned COARSE_SLICE_CYC = COARSE_SLICE_US * SYS_CLK_MHZ;
  localparam int unsigned COARSE_SLICES = 64;
  localparam int unsigned COARSE_IDX_W = 6;

  // Reset stretch: machine cycles after the pin goes high
  localparam int unsigned RST_MC = 3;
  localparam int unsigned MC_NS = OSC_PER_MC * 1000 / OSC_MHZ;
  localparam int unsigned RST_STRETCH_CYC =
    (RST_MC * MC_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned RST_CNT_W = 10;

  // Latch layout
  localparam int unsigned FINE_LATCH_W = 15;
  localparam int unsigned FINE_PORT_BIT = 14;
  localparam int unsigned FINE_UPPER_LSB = 6;
  localparam int unsigned COARSE_LATCH_W = 7;
  localparam int unsigned COARSE_FULL_BIT = 6;

  // Reset values
  localparam logic [14:0] FINE_LATCH_RST = 15'h0000;
  localparam logic [6:0] COARSE_LATCH_RST = 7'h00;

  // RAM nibbles at bank 0 addresses 0 to 3
  typedef struct packed {
    logic [3:0] nib3;
    logic [3:0] nib2;
    logic [3:0] nib1;
    logic [3:0] nib0;
  } dpwm_fine_src_t;

  // Working registers B (low 3 bits) and A
  typedef struct packed {
    logic [2:0] reg_b;
    logic [3:0] reg_a;
  } dpwm_coarse_src_t;

  // Spread of a 6-bit value over slots 1..64; slot 64 arrives as 0.
  // Lowest set bit of the slot picks which value bit applies.
  function automatic logic dpwm_spread(input logic [5:0] val,
                                       input logic [5:0] m);
    logic r;
    r = 1'b0;
    casez (m)
      6'b?????1: r = val[5];
      6'b????10: r = val[4];
      6'b???100: r = val[3];
      6'b??1000: r = val[2];
      6'b?10000: r = val[1];
      6'b100000: r = val[0];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// ==== dpwm_slice_gen.sv ====
`timescale 1ns/100ps
module dpwm_slice_gen #(
  parameter int unsigned SLICE_CYC = 25,
  parameter int unsigned IDX_W = 14
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic [IDX_W-1:0] idx,
  output logic tick,
  output logic wrap
);

  localparam int unsigned PRE_W = $clog2(SLICE_CYC + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SLICE_CYC - 1);

  logic [PRE_W-1:0] pre_r;
  logic last_c;

  assign last_c = (pre_r == PRE_LAST);
  // Tick marks the last system cycle of each slice
  assign tick = last_c;
  assign wrap = last_c && (&idx);

  ////////////////////////////////////////////////////////////////////
  // Prescaler: one slice per SLICE_CYC system cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst || last_c)
      pre_r <= '0;
    else
      pre_r <= pre_r + PRE_W'(1);
  end

  // Slice index, wraps naturally at the end of the full period
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      idx <= '0;
    else if (last_c)
      idx <= idx + IDX_W'(1);
  end

endmodule // dpwm_slice_gen

// ==== dpwm_monitor.sv ====
`timescale 1ns/100ps
module dpwm_monitor #(
  parameter bit FINE_INVERT = 1'b0,
  parameter bit COARSE_INVERT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_n_pin,
  input wire logic fine_load,
  input wire dpwm_pkg::dpwm_fine_src_t fine_src,
  input wire logic fine_port_mode,
  input wire logic coarse_latch_load_instr,
  input wire dpwm_pkg::dpwm_coarse_src_t coarse_src,
  input wire logic coarse_port_mode,
  input wire logic coarse_port_data,
  input wire logic fine_pwm_o,
  input wire logic coarse_pwm_port_o,
  input wire logic coarse_pwm_port_oe,
  input wire logic rst_int_o
);
  logic [2:0] cq_r;
  logic [2:0] fq_r;
  logic ok_r;
  wire run = reset_n_pin && !rst_int_o && !sys_rst;
  wire safe = run && ok_r;
  wire cq = &cq_r && run && !coarse_port_mode;
  wire fq = &fq_r && run && !fine_port_mode;

  // History of a settled mode; mode or reset edges may cut a slice short
  always_ff @(posedge sys_clk)
  begin
    ok_r <= run;
    cq_r <= {cq_r[1:0], run && !coarse_port_mode};
    fq_r <= {fq_r[1:0], run && !fine_port_mode};
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  //////////////////////////////////////////////////////////////////////
  a_od_data_low:
  assert property (coarse_pwm_port_o == 1'b0) else $error("od data high");
  a_fine_rst_level:
  assert property (rst_int_o && $past(rst_int_o)
    |-> fine_pwm_o == FINE_INVERT) else $error("fine active in reset");
  a_coarse_rst_rel:
  assert property (rst_int_o && $past(rst_int_o)
    |-> !coarse_pwm_port_oe) else $error("coarse driven in reset");
  a_rst_enter:
  assert property (!reset_n_pin |-> ##[1:2] rst_int_o)
    else $error("reset pin ignored");
  a_rst_stretch:
  assert property ($rose(reset_n_pin) |=> rst_int_o [*4])
    else $error("reset stretch short");
  // Bound covers the full stretch plus the two register stages
  a_rst_release:
  assert property ($rose(reset_n_pin)
    |-> ##[1:610] (!rst_int_o || !reset_n_pin)) else $error("reset stuck");
  a_coarse_port_map:
  assert property (coarse_port_mode && safe |=> coarse_pwm_port_oe ==
    !($past(coarse_port_data) ^ COARSE_INVERT)) else $error("port bad");
  a_fine_port_hold:
  assert property (fine_port_mode && $past(fine_port_mode, 2) && safe
    && !$past(fine_load) && !$past(fine_load, 2) |-> $stable(fine_pwm_o))
    else $error("fine port moved");
  a_coarse_width:
  assert property (cq && $changed(coarse_pwm_port_oe)
    |=> $stable(coarse_pwm_port_oe)) else $error("coarse sliver");
  a_fine_width:
  assert property (fq && $changed(fine_pwm_o) |=> $stable(fine_pwm_o))
    else $error("fine sliver");

  c_fine_high: cover property (fq && $rose(fine_pwm_o));
  c_coarse_port: cover property (coarse_port_mode && coarse_pwm_port_oe);
  c_rst_pin: cover property ($fell(reset_n_pin));
endmodule // dpwm_monitor

bind dpwm_top dpwm_monitor #(
  .FINE_INVERT(FINE_INVERT),
  .COARSE_INVERT(COARSE_INVERT)
) u_mon (.sys_clk, .sys_rst, .reset_n_pin, .fine_load, .fine_src,
  .fine_port_mode, .coarse_latch_load_instr, .coarse_src,
  .coarse_port_mode, .coarse_port_data, .fine_pwm_o, .coarse_pwm_port_o,
  .coarse_pwm_port_oe, .rst_int_o);

// ==== dpwm_rc_model.sv ====
`timescale 1ns/100ps
module dpwm_rc_model (
  input wire logic sys_clk,
  input wire logic fine_in,
  input wire logic od_data,
  input wire logic od_en,
  output logic coarse_pin,
  output logic [31:0] fine_hi,
  output logic [31:0] coarse_hi
);
  // Pull-up lifts the released open-drain pin
  assign coarse_pin = od_en ? od_data : 1'b1;

  // Integrator charge kept as a running count of high cycles
  initial
  begin
    fine_hi = 32'h0;
    coarse_hi = 32'h0;
  end
  always @(posedge sys_clk)
  begin
    fine_hi <= fine_hi + {31'h0, fine_in === 1'b1};
    coarse_hi <= coarse_hi + {31'h0, coarse_pin === 1'b1};
  end
endmodule // dpwm_rc_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_n_pin = 1'b1;
  logic fine_load = 1'b0;
  dpwm_pkg::dpwm_fine_src_t fine_src = 16'h0000;
  logic fine_port_mode = 1'b0;
  logic coarse_load = 1'b0;
  dpwm_pkg::dpwm_coarse_src_t coarse_src = 7'h00;
  logic coarse_port_mode = 1'b0;
  logic coarse_port_data = 1'b0;
  logic fine_pwm, od_o, od_oe, rst_int, fine_inv, rst_inv, coarse_pin;
  logic [31:0] fine_hi, coarse_hi;
  int mismatches = 0;
  int num_checks = 0;

  // Short slices keep the run brief; reset stretch keeps its real length
  dpwm_top #(.FINE_SLICE_CYC(2), .COARSE_SLICE_CYC(2))
    dut (.sys_clk, .sys_rst, .reset_n_pin,
    .fine_load, .fine_src, .fine_port_mode,
    .coarse_latch_load_instr(coarse_load), .coarse_src,
    .coarse_port_mode, .coarse_port_data, .fine_pwm_o(fine_pwm),
    .coarse_pwm_port_o(od_o), .coarse_pwm_port_oe(od_oe),
    .rst_int_o(rst_int));
  // Twin only feeds the fine compare, so its coarse side stays default
  dpwm_top #(.FINE_INVERT(1'b1), .FINE_SLICE_CYC(2))
    dut_inv (.sys_clk, .sys_rst, .reset_n_pin, .fine_load, .fine_src,
    .fine_port_mode, .coarse_latch_load_instr(coarse_load), .coarse_src,
    .coarse_port_mode, .coarse_port_data, .fine_pwm_o(fine_inv),
    .coarse_pwm_port_o(), .coarse_pwm_port_oe(), .rst_int_o(rst_inv));
  dpwm_rc_model rc (.sys_clk, .fine_in(fine_pwm), .od_data(od_o),
    .od_en(od_oe), .coarse_pin, .fine_hi, .coarse_hi);

  always #10 sys_clk = ~sys_clk;

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic load_fine(input logic [15:0] v);
    fine_src = v;
    fine_load = 1'b1;
    cyc(1);
    fine_load = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset_pin();
    reset_n_pin = 1'b0;
    cyc(2);
    reset_n_pin = 1'b1;
    cyc(598);
    check({31'h0, rst_int}, 32'h1);
    cyc(6);
    check({31'h0, rst_int}, 32'h0);
  endtask

  // Each level measured over one whole period after it took effect
  task automatic t_coarse_levels();
    logic [6:0] v[10] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10,
      7'h20, 7'h40, 7'h7f, 7'h3f};
    logic [31:0] b;
    logic [31:0] e;
    foreach (v[i])
    begin
      coarse_src = v[i];
      coarse_load = 1'b1;
      cyc(1);
      coarse_load = 1'b0;
      cyc(384);
      b = coarse_hi;
      cyc(128);
      e = v[i][6] ? 32'h80 : {25'h0, v[i][5:0], 1'b0};
      check(coarse_hi - b, e);
    end
  endtask

  task automatic t_coarse_port();
    coarse_port_mode = 1'b1;
    cyc(3);
    check({31'h0, coarse_pin}, 32'h0);
    coarse_port_data = 1'b1;
    cyc(3);
    check({31'h0, coarse_pin}, 32'h1);
    coarse_port_mode = 1'b0;
  endtask

  // Loaded fine value must wait for the period wrap
  task automatic t_fine_hold();
    logic [31:0] b;
    load_fine(16'h80c5);
    b = fine_hi;
    t_coarse_levels();
    t_coarse_port();
    check(fine_hi - b, 32'h0);
  endtask

  task automatic t_fine_levels();
    logic [31:0] b;
    cyc(32768);
    b = fine_hi;
    cyc(32768);
    check(fine_hi - b, 32'h18a);
  endtask

  task automatic t_fine_port();
    fine_port_mode = 1'b1;
    cyc(3);
    check({31'h0, fine_pwm}, 32'h0);
    load_fine(16'h40c5);
    cyc(3);
    check({31'h0, fine_pwm}, 32'h1);
    fine_port_mode = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Inverted twin mirrors the fine pin whenever out of reset
  always @(negedge sys_clk)
    if (rst_int === 1'b0 && rst_inv === 1'b0)
      check({31'h0, fine_inv}, {31'h0, ~fine_pwm});

  initial
  begin
    cyc(10);
    sys_rst = 1'b0;
    cyc(8);
    check({31'h0, fine_pwm}, 32'h0);
    check({31'h0, coarse_pin}, 32'h1);
    t_reset_pin();
    t_fine_hold();
    t_fine_levels();
    t_fine_port();
    summarize();
  end

  // Watchdog well beyond the expected 71k cycles
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
endmodule // tb_top
